// ### design/asp_spi_port.sv
`timescale 1ns/100ps
module asp_spi_port #(
    parameter int unsigned AXIS_BITS     = 16,      // width of one acceleration value
    parameter logic [7:0]  REVISION_CODE = 8'h5A,   // arbitrary value
    parameter logic        MULTI_AXIS    = 1'b1     // 1 on multi-axis variants
) (
    // clock, reset and enable
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    // serial pins
    input  wire logic                 select_low_i,
    input  wire logic                 sck_i,
    input  wire logic                 mosi_i,
    output logic                      miso_o,
    output logic                      miso_oe_o,
    // sensor side
    input  wire logic [AXIS_BITS-1:0] accel_x_i,
    input  wire logic [AXIS_BITS-1:0] accel_y_i,
    input  wire logic [AXIS_BITS-1:0] accel_z_i,
    input  wire logic                 diagnostic_alarm_i,
    input  wire logic                 clip_flag_i,
    input  wire logic                 undervoltage_i,
    input  wire logic [7:0]           nvm_component_code_i
);
    import asp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check: two frames carry exactly one value
    if (AXIS_BITS != 2 * DATA_BITS) begin : g_bad_width
        $error("AXIS_BITS must be twice the byte width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    asp_state_t  state;                             // frame state
    logic [4:0]  cnt;                               // rising serial clocks in this frame
    logic [15:0] rx;                                // received bits, first bit on top
    logic        miso_q;                            // output line flop
    logic [7:0]  read_byte;                         // byte answered in this frame
    logic [3:0]  hdr;                               // frame error, reset, alarm, clip
    logic [7:0]  ctrl;                              // control, flag bit unused here
    logic        power_on_reset_flag;                             // power_on_reset_flag
    logic [7:0]  component_code;                    // user-visible copy
    logic        loaded;                            // non-volatile copy taken
    logic        frame_err;                         // frame_error_flag
    asp_state_t  next_state;
    logic [4:0]  next_cnt;
    logic [15:0] next_rx;
    logic [7:0]  next_read_byte, next_ctrl, next_component_code;
    logic [3:0]  next_hdr;
    logic        next_miso, next_power_on_reset_flag, next_loaded, next_frame_err;

    // pin edges
    logic sck_rise, sck_fall, sel_rise, sel_fall;

    asp_edge #(.RESET_LEVEL(1'b0)) u_sck_edge (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .level_i   (sck_i),
        .rise_o    (sck_rise),
        .fall_o    (sck_fall)
    );

    asp_edge #(.RESET_LEVEL(1'b1)) u_sel_edge (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .level_i   (select_low_i),
        .rise_o    (sel_rise),
        .fall_o    (sel_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoding shared by the read path and the checks
    function automatic logic addr_mapped(input logic [5:0] a);
        case (a)
            ADDR_REVISION, ADDR_CTRL, ADDR_STATUS, ADDR_X_LOW, ADDR_X_HIGH,
            ADDR_Y_LOW, ADDR_Y_HIGH, ADDR_Z_LOW, ADDR_Z_HIGH,
            ADDR_COMPONENT: addr_mapped = 1'b1;
            default:        addr_mapped = 1'b0;
        endcase
    endfunction

    // register contents as seen at the address capture point
    function automatic logic [7:0] reg_read(input logic [5:0] a);
        reg_read = READ_RESERVED;
        case (a)
            ADDR_REVISION:  reg_read = REVISION_CODE;
            ADDR_CTRL: begin
                reg_read = ctrl;
                reg_read[CTRL_POWER_ON_RESET_FLAG_BIT] = power_on_reset_flag;
            end
            ADDR_STATUS:    reg_read[STAT_FRAME_ERROR_FLAG_BIT] = frame_err;
            ADDR_X_LOW:     reg_read = accel_x_i[7:0];
            ADDR_X_HIGH:    reg_read = accel_x_i[15:8];
            ADDR_Y_LOW:     reg_read = accel_y_i[7:0];
            ADDR_Y_HIGH:    reg_read = accel_y_i[15:8];
            ADDR_Z_LOW:     reg_read = accel_z_i[7:0];
            ADDR_Z_HIGH:    reg_read = accel_z_i[15:8];
            ADDR_COMPONENT: reg_read = component_code;
            default:        reg_read = READ_RESERVED;
        endcase
    endfunction

    // value of output bit number idx (1..16) of the current frame
    function automatic logic out_bit(input logic [4:0] idx, input logic [3:0] h,
                                     input logic [7:0] rb);
        case (idx)
            HDR_FRAME_ERROR_FLAG_IDX:  out_bit = h[3];
            HDR_POWER_ON_RESET_FLAG_IDX: out_bit = h[2];
            HDR_ALARM_IDX: out_bit = h[1];
            HDR_CLIP_IDX:  out_bit = h[0];
            HDR_ZERO_IDX:  out_bit = 1'b0;
            HDR_ONE_IDX:   out_bit = 1'b1;
            HDR_DATA_PARITY_IDX:  out_bit = ~^rb;
            default: begin
                // data bits, most significant first; bit 1 is left at zero
                if (idx > HDR_DATA_PARITY_IDX && idx <= DATA_LAST_IDX) begin
                    out_bit = rb[3'(DATA_LAST_IDX - idx)];
                end else begin
                    out_bit = 1'b0;
                end
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // frame close decisions
    logic       close;                              // select rose while in a frame
    logic       len_ok;                             // exactly sixteen rising clocks
    logic       par_ok;                             // odd ones over address byte
    logic       frame_bad;                          // invalid frame
    logic       do_write;                           // accepted write at this close
    logic [5:0] wr_addr;
    logic [7:0] wr_data;

    assign close     = (state == ST_FRAME) && sel_rise;
    assign len_ok    = (cnt == CNT_FULL);
    assign par_ok    = ^rx[RX_ADDR_MSB:RX_ADDRESS_PARITY_BIT];
    assign frame_bad = !len_ok || !par_ok;
    assign wr_addr   = rx[RX_ADDR_MSB:RX_ADDR_LSB];
    assign wr_data   = rx[7:0];
    // a read with bad address parity still answers, but the flag is raised
    assign do_write  = close && !frame_bad && rx[RX_DIR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // frame engine: next values
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_rx        = rx;
        next_miso      = miso_q;
        next_read_byte = read_byte;
        next_hdr       = hdr;
        case (state)
            ST_IDLE: begin
                if (sel_fall) begin
                    next_state = ST_FRAME;
                    next_cnt   = '0;
                    next_miso  = 1'b0;
                    // status snapshot so the header is stable for the frame
                    next_hdr   = {frame_err, power_on_reset_flag, diagnostic_alarm_i, clip_flag_i};
                end
            end
            ST_FRAME: begin
                if (sel_rise) begin
                    next_state = ST_IDLE;
                end else begin
                    if (sck_rise) begin
                        next_rx = {rx[14:0], mosi_i};
                        // saturate so an overlong frame never wraps to sixteen
                        if (cnt != CNT_SAT) begin
                            next_cnt = cnt + 5'h01;
                        end
                        // the sixth bit completes the address: fetch the answer
                        if (cnt == CNT_ADDR) begin
                            next_read_byte = reg_read({rx[4:0], mosi_i});
                        end
                    end
                    // output moves on the fall only, one bit ahead of sampling
                    if (sck_fall && cnt != '0 && cnt < CNT_FULL) begin
                        next_miso = out_bit(cnt + 5'h01, hdr, read_byte);
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // frame engine: registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= ST_IDLE;
            cnt       <= '0;
            rx        <= '0;
            miso_q    <= 1'b0;
            read_byte <= '0;
            hdr       <= '0;
        end else if (ce_i) begin
            state     <= next_state;
            cnt       <= next_cnt;
            rx        <= next_rx;
            miso_q    <= next_miso;
            read_byte <= next_read_byte;
            hdr       <= next_hdr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file: next values
    always_comb begin
        next_ctrl           = ctrl;
        next_power_on_reset_flag          = power_on_reset_flag;
        next_component_code = component_code;
        next_loaded         = 1'b1;
        next_frame_err      = frame_err;
        // non-volatile copy is taken once, after reset release
        if (!loaded) begin
            next_component_code = nvm_component_code_i;
            next_component_code[COMP_MULTI_BIT] = MULTI_AXIS;
        end
        if (close) begin
            next_frame_err = frame_bad;
        end
        if (do_write) begin
            case (wr_addr)
                ADDR_CTRL: begin
                    next_ctrl = wr_data;
                    // the flag can only be cleared from the serial side
                    if (!wr_data[CTRL_POWER_ON_RESET_FLAG_BIT]) begin
                        next_power_on_reset_flag = 1'b0;
                    end
                end
                // user writes replace the user-visible copy, never the non-volatile source
                ADDR_COMPONENT: next_component_code = wr_data;
                default: next_ctrl = ctrl;
            endcase
        end
        // an undervoltage event wins over a clear in the same cycle
        if (undervoltage_i) begin
            next_power_on_reset_flag = 1'b1;
        end
    end

    // register file: registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl           <= CTRL_RESET;
            power_on_reset_flag          <= POWER_ON_RESET_FLAG_RESET;
            component_code <= COMP_RESET;
            loaded         <= 1'b0;
            frame_err      <= 1'b0;
        end else if (ce_i) begin
            ctrl           <= next_ctrl;
            power_on_reset_flag          <= next_power_on_reset_flag;
            component_code <= next_component_code;
            loaded         <= next_loaded;
            frame_err      <= next_frame_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the enable follows the pin directly: the line is driven as select falls, the first bit one clock later
    assign miso_o    = miso_q;
    assign miso_oe_o = !select_low_i && !ctrl[CTRL_OUTDIS_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_float_idle: assert property (select_low_i |-> !miso_oe_o)
        else $error("output driven while select high");
    a_disable_float: assert property (ctrl[CTRL_OUTDIS_BIT] |-> !miso_oe_o)
        else $error("output driven while disabled");
    a_first_bit_drive: assert property (
        ce_i && state == ST_IDLE && sel_fall && !ctrl[CTRL_OUTDIS_BIT] |=> miso_oe_o && !miso_o)
        else $error("first bit not driven at select fall");
    a_miso_on_fall: assert property (
        ce_i && state == ST_FRAME && !sck_fall |=> $stable(miso_q))
        else $error("output changed away from a clock fall");
    a_fixed_zero: assert property (
        ce_i && state == ST_FRAME && !sel_rise && sck_fall && cnt == 5'h05 |=> !miso_q)
        else $error("fixed zero header bit wrong");
    a_fixed_one: assert property (
        ce_i && state == ST_FRAME && !sel_rise && sck_fall && cnt == 5'h06 |=> miso_q)
        else $error("fixed one header bit wrong");
    a_parity_odd: assert property (
        ce_i && state == ST_FRAME && !sel_rise && sck_fall && cnt == 5'h07 |=> miso_q == ~^read_byte)
        else $error("data parity not odd");
    a_reserved_zero: assert property (
        ce_i && state == ST_FRAME && !sel_rise && sck_rise && cnt == CNT_ADDR
        && !addr_mapped({rx[4:0], mosi_i}) |=> read_byte == READ_RESERVED)
        else $error("reserved address did not read zero");
    a_short_frame_err: assert property (
        ce_i && close && cnt != CNT_FULL |=> frame_err && $stable(component_code))
        else $error("short frame not flagged");
    a_bad_write_kept: assert property (
        ce_i && close && len_ok && !par_ok && rx[RX_DIR_BIT] && loaded
        |=> frame_err && $stable(component_code) && $stable(ctrl))
        else $error("write with bad parity took effect");
    a_power_on_reset_flag_clear: assert property (
        ce_i && do_write && wr_addr == ADDR_CTRL && !wr_data[CTRL_POWER_ON_RESET_FLAG_BIT]
        && !undervoltage_i |=> !power_on_reset_flag)
        else $error("reset flag not cleared by write of zero");
    a_power_on_reset_flag_set: assert property (ce_i && undervoltage_i |=> power_on_reset_flag)
        else $error("reset flag missed an undervoltage event");
    a_good_write: assert property (
        ce_i && do_write && wr_addr == ADDR_COMPONENT |=> component_code == $past(wr_data))
        else $error("valid write not stored at select rise");
endmodule

// ### shared/asp_pkg.sv
// shared constants of the accelerometer serial slave port
package asp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame geometry
    localparam int unsigned FRAME_BITS = 16;        // serial clocks in a normal frame
    localparam int unsigned ADDR_BITS  = 6;         // register address width
    localparam int unsigned DATA_BITS  = 8;         // register and data byte width
    localparam int unsigned CNT_BITS   = 5;         // width of the serial clock counter
    localparam logic [4:0]  CNT_FULL   = 5'h10;     // counter value of a complete frame
    localparam logic [4:0]  CNT_SAT    = 5'h1F;     // counter stops here on overlong frames
    localparam logic [4:0]  CNT_ADDR   = 5'h05;     // rising edges seen before the last address bit

    ////////////////////////////////////////////////////////////////////////////
    // positions inside the received 16-bit word (bit 15 arrives first)
    localparam int unsigned RX_ADDR_MSB = 15;       // top address bit
    localparam int unsigned RX_ADDR_LSB = 10;       // bottom address bit
    localparam int unsigned RX_DIR_BIT  = 9;        // direction bit, 1 means write
    localparam int unsigned RX_ADDRESS_PARITY_BIT = 8;        // address parity bit

    ////////////////////////////////////////////////////////////////////////////
    // header bit numbers on the output line, counted from 1
    localparam logic [4:0] HDR_FRAME_ERROR_FLAG_IDX  = 5'h02;   // previous frame error
    localparam logic [4:0] HDR_POWER_ON_RESET_FLAG_IDX = 5'h03;   // power-on reset flag
    localparam logic [4:0] HDR_ALARM_IDX = 5'h04;   // diagnostic alarm
    localparam logic [4:0] HDR_CLIP_IDX  = 5'h05;   // clip flag
    localparam logic [4:0] HDR_ZERO_IDX  = 5'h06;   // fixed zero
    localparam logic [4:0] HDR_ONE_IDX   = 5'h07;   // fixed one
    localparam logic [4:0] HDR_DATA_PARITY_IDX  = 5'h08;   // data parity
    localparam logic [4:0] DATA_LAST_IDX = 5'h10;   // last data bit

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [5:0] ADDR_REVISION  = 6'h00;  // revision_code, read only
    localparam logic [5:0] ADDR_CTRL      = 6'h01;  // control
    localparam logic [5:0] ADDR_STATUS    = 6'h02;  // status
    localparam logic [5:0] ADDR_X_LOW     = 6'h04;  // x acceleration, low byte
    localparam logic [5:0] ADDR_X_HIGH    = 6'h05;  // x acceleration, high byte
    localparam logic [5:0] ADDR_Y_LOW     = 6'h06;  // y acceleration, low byte
    localparam logic [5:0] ADDR_Y_HIGH    = 6'h07;  // y acceleration, high byte
    localparam logic [5:0] ADDR_Z_LOW     = 6'h08;  // z acceleration, low byte
    localparam logic [5:0] ADDR_Z_HIGH    = 6'h09;  // z acceleration, high byte
    localparam logic [5:0] ADDR_COMPONENT = 6'h27;  // component_code

    ////////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int unsigned CTRL_POWER_ON_RESET_FLAG_BIT  = 6;    // power_on_reset_flag in control
    localparam int unsigned CTRL_OUTDIS_BIT = 0;    // output_disable_bit in control
    localparam int unsigned STAT_FRAME_ERROR_FLAG_BIT   = 0;    // frame_error_flag in status
    localparam int unsigned COMP_MULTI_BIT  = 7;    // axis-count bit of component_code
    localparam logic [7:0]  CTRL_RESET      = 8'h00;   // control bits other than the flag
    localparam logic [7:0]  COMP_RESET      = 8'h00;   // before the non-volatile load
    localparam logic [7:0]  READ_RESERVED   = 8'h00;   // answer for unmapped addresses
    localparam logic        POWER_ON_RESET_FLAG_RESET     = 1'b1;    // flag stands after power-up

    ////////////////////////////////////////////////////////////////////////////
    // frame state
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,                            // select high, line floated
        ST_FRAME = 1'b1                             // select low, shifting
    } asp_state_t;

endpackage

// ### design/asp_edge.sv
`timescale 1ns/100ps
// edge finder for a pin that is already synchronous to the system clock
module asp_edge #(
    parameter logic RESET_LEVEL = 1'b0              // idle level of the pin
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // pin and its edges
    input  wire logic level_i,
    output logic      rise_o,
    output logic      fall_o
);

    logic last;                                     // pin level one enabled cycle ago
    logic next_last;

    // edges are gated by the enable so that a frozen block sees none
    assign rise_o = ce_i & level_i & ~last;
    assign fall_o = ce_i & ~level_i & last;

    // next value of the history flop
    always_comb begin
        next_last = level_i;
    end

    // history flop holds while the enable is low
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last <= RESET_LEVEL;
        end else if (ce_i) begin
            last <= next_last;
        end
    end

endmodule

// ### testbench/asp_master_model.sv
`timescale 1ns/100ps
// spi master model: each level stands 2+ clocks, miso sampled before each rise
module asp_master_model (
    input  wire logic   sys_clk_i,
    input  wire logic   miso_i,
    output logic        select_low_o,
    output logic        sck_o,
    output logic        mosi_o,
    output logic        done_o,
    output logic [15:0] rx_o
);
    initial {select_low_o, sck_o, mosi_o, done_o, rx_o} = {3'b100, 17'h0_0000};
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // n clocks, msb first, sck idles low, select framing
    task automatic frame(input logic [15:0] tx, input int n);
        select_low_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            wt(2);
            mosi_o = tx[i];
            wt(2);
            rx_o[i] = miso_i;
            sck_o = 1'b1;
            wt(2);
            sck_o = 1'b0;
        end
        wt(3);
        select_low_o = 1'b1;
        done_o = 1'b1;
        wt(1);
        done_o = 1'b0;
        wt(2);
    endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import asp_pkg::*;
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, tog = 1'b0;
    logic        alarm = 1'b0, clip = 1'b0, uv = 1'b0, off = 1'b0, ce = 1'b1;
    logic        sel, sck, mosi, miso, oe, done, power_on_reset_flag = 1'b1, frame_error_flag = 1'b0;
    logic [15:0] ax, ay, az, rx;
    logic [15:0] exp_q[$], msk_q[$];
    logic [7:0]  nvm, comp;
    int          err_total = 0, cmp_count = 0, seed = 8907;
    always #25 sys_clk_i = ~sys_clk_i;
    // a released line toggles so a stale bit never passes
    always @(posedge sys_clk_i) tog <= ~tog;
    asp_spi_port #(.REVISION_CODE(8'h3C), .MULTI_AXIS(1'b0)) u_asp_spi_port (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .select_low_i(sel),
        .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe), .accel_x_i(ax),
        .accel_y_i(ay), .accel_z_i(az), .diagnostic_alarm_i(alarm), .clip_flag_i(clip),
        .undervoltage_i(uv), .nvm_component_code_i(nvm));
    asp_master_model u_asp_master_model (.sys_clk_i(sys_clk_i), .miso_i(oe ? miso : tog),
        .select_low_o(sel), .sck_o(sck), .mosi_o(mosi), .done_o(done), .rx_o(rx));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge done) chk(rx & msk_q.pop_front(), exp_q.pop_front());
    always @(negedge sys_clk_i) if (sel === 1'b1 || off) chk({15'h0000, oe}, 16'h0000);
    // one frame; header expected from tracked flags, undefined bit1 masked
    task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d,
                        input logic [7:0] e, input int n = 16, input logic bp = 1'b0);
        logic [15:0] m;
        m = (n == 16 && !off) ? 16'h7FFF : 16'h0000;
        {alarm, clip} = 2'($random(seed));
        exp_q.push_back(m & {1'b0, frame_error_flag, power_on_reset_flag, alarm, clip, 2'b01, ~^e, e});
        msk_q.push_back(m);
        u_asp_master_model.frame({a, w, ~^{a, w} ^ bp, d}, n);
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        err_total++;
        stop_test();
    end
    initial begin
        {ax, ay, az, nvm} = 56'({$random(seed), $random(seed)});
        // top bit set so a single-axis part must visibly override it
        nvm[7] = 1'b1;
        repeat (10) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1 comp = {1'b0, nvm[6:0]};
        xfer(ADDR_REVISION, 1'b0, 8'hFF, 8'h3C);
        xfer(ADDR_COMPONENT, 1'b0, 8'h00, comp);
        xfer(ADDR_COMPONENT, 1'b1, ~comp, comp);
        comp = ~comp;
        xfer(ADDR_COMPONENT, 1'b1, 8'h00, comp, 8);
        frame_error_flag = 1'b1;
        xfer(ADDR_COMPONENT, 1'b1, 8'h00, comp, 16, 1'b1);
        xfer(ADDR_STATUS, 1'b0, 8'h00, 8'h01);
        frame_error_flag = 1'b0;
        xfer(ADDR_COMPONENT, 1'b0, 8'h00, comp);
        for (int k = 0; k < 6; k++) xfer(6'(4 + k), 1'b0, 8'($random(seed)),
            8'({az, ay, ax} >> (8 * k)));
        xfer(6'h3F, 1'b0, 8'h00, READ_RESERVED);
        xfer(ADDR_CTRL, 1'b1, 8'h41, 8'h40);
        off = 1'b1;
        xfer(ADDR_CTRL, 1'b1, 8'h40, 8'h41);
        off = 1'b0;
        xfer(ADDR_CTRL, 1'b1, 8'h00, 8'h40);
        power_on_reset_flag = 1'b0;
        // an undervoltage pulse while the enable is low must leave the flag clear
        ce = 1'b0;
        uv = 1'b1;
        @(posedge sys_clk_i);
        #1 uv = 1'b0;
        ce = 1'b1;
        xfer(ADDR_STATUS, 1'b0, 8'h00, 8'h00);
        uv = 1'b1;
        @(posedge sys_clk_i);
        #1 uv = 1'b0;
        power_on_reset_flag = 1'b1;
        xfer(ADDR_CTRL, 1'b0, 8'h00, 8'h40);
        stop_test();
    end
endmodule
